// ===== rtl/ebtl_pkg.sv
// Purpose: Shared constants and types for the break and trace logic
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Range tables sit in three banks of start/end word pairs
package ebtl_pkg;
  // Sizes
  localparam int EBTL_AW = 16;       // Emulated address width
  localparam int EBTL_NRANGE = 16;   // Ranges per bank
  localparam int EBTL_NPROBE = 8;    // External trace probes

  // Register byte offsets
  localparam logic [11:0] EBTL_CTRL_OFS = 12'h000;
  localparam logic [11:0] EBTL_STAT_OFS = 12'h004;   // Sticky, write one to clear
  localparam logic [11:0] EBTL_MASK_OFS = 12'h008;
  localparam logic [11:0] EBTL_STATE_OFS = 12'h00c;  // Live state, read only
  localparam logic [11:0] EBTL_PADDR_OFS = 12'h010;  // Pass qualifier address
  localparam logic [11:0] EBTL_PCNT_OFS = 12'h014;   // Pass count target
  localparam logic [11:0] EBTL_BRKEN_OFS = 12'h018;  // Break range enables
  localparam logic [11:0] EBTL_TRCEN_OFS = 12'h01c;  // Trace range enables
  localparam logic [11:0] EBTL_TRGEN_OFS = 12'h020;  // Trigger range enables
  localparam logic [11:0] EBTL_CMD_OFS = 12'h024;    // Bit 0 restarts emulation

  // Range banks: paddr[9:8] picks bank, [6:3] entry, [2] end word
  localparam logic [1:0] EBTL_BANK_BRK = 2'h1;
  localparam logic [1:0] EBTL_BANK_TRC = 2'h2;
  localparam logic [1:0] EBTL_BANK_TRG = 2'h3;

  // Control fields
  localparam int EBTL_C_EXT_EN = 0;   // External halt input enabled
  localparam int EBTL_C_AND = 1;      // 1 = AND with internal, 0 = OR
  localparam int EBTL_C_FALL = 2;     // 1 = falling edge, 0 = rising edge
  localparam int EBTL_C_MODE = 3;     // Two-bit capture mode
  localparam int EBTL_C_QUAL_EN = 5;  // Pass qualifier enabled
  localparam int EBTL_C_QUAL_BRK = 6; // 1 = qualifier to break, 0 = to trace
  localparam int EBTL_C_TRC_EN = 7;   // Trace capture enabled
  localparam logic [7:0] EBTL_CTRL_RST = 8'h80;

  // Status and mask bits
  localparam int EBTL_S_HALT = 0;
  localparam int EBTL_S_EXT = 1;
  localparam int EBTL_S_TRIG = 2;
  localparam int EBTL_NSTAT = 3;
  localparam logic [2:0] EBTL_MASK_RST = 3'h0;

  // Capture modes
  typedef enum logic [1:0] {
    EBTL_CAP_ALL = 2'b00,
    EBTL_CAP_FIRST = 2'b01,
    EBTL_CAP_DATA = 2'b10
  } ebtl_cap_t;

  // One bus cycle of the emulated processor
  typedef struct packed {
    logic valid;                // Cycle present this clock
    logic first;                // First cycle of an instruction
    logic table_cycle;          // Second cycle of table read or write
    logic [EBTL_AW-1:0] addr;   // Executed address
  } ebtl_cyc_t;

  // One trace buffer entry
  typedef struct packed {
    logic [EBTL_AW-1:0] addr;
    logic [EBTL_NPROBE-1:0] probes;  // MSB is trace_probe_msb
  } ebtl_trace_t;
endpackage

// ===== rtl/ebtl_range_bank.sv
// Purpose: Sixteen start/end address ranges and their match logic
// Assumes: Ranges are inclusive at both ends
// Notes: A range whose end is below its start never matches
`timescale 1ns/1ps
module ebtl_range_bank import ebtl_pkg::*; (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Table write and read back
  input wire logic wr_i,
  input wire logic [3:0] idx_i,
  input wire logic end_sel_i,
  input wire logic [EBTL_AW-1:0] data_i,
  output logic [EBTL_AW-1:0] rd_o,
  // Match
  input wire logic [EBTL_NRANGE-1:0] en_i,
  input wire logic [EBTL_AW-1:0] addr_i,
  output logic hit_o
);
  logic [EBTL_AW-1:0] start_r [EBTL_NRANGE];  // Range starts
  logic [EBTL_AW-1:0] end_r [EBTL_NRANGE];    // Range ends
  logic [EBTL_NRANGE-1:0] hit_vec;            // Per-entry match

  // Table storage
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < EBTL_NRANGE; i++) begin
        start_r[i] <= '0;
        end_r[i] <= '0;
      end
    end else if (wr_i) begin
      if (end_sel_i) begin
        end_r[idx_i] <= data_i;
      end else begin
        start_r[idx_i] <= data_i;
      end
    end
  end

  // One comparator pair per entry
  for (genvar g = 0; g < EBTL_NRANGE; g++) begin : g_cmp
    assign hit_vec[g] = en_i[g] && (addr_i >= start_r[g]) && (addr_i <= end_r[g]);
  end

  assign hit_o = |hit_vec;
  assign rd_o = end_sel_i ? end_r[idx_i] : start_r[idx_i];
endmodule // ebtl_range_bank

// ===== rtl/ebtl_core.sv
// Purpose: Break, trigger and trace qualification of an emulator pod
// Assumes: One cycle record per clock at most, on the emulated clock
// Notes: Registers over APB, one wait-free access phase
// How it works
// - OR mode halts on first break of either kind
// - AND mode needs latched edge plus range match or qualifier break
// - External halt latches on selectable edge
// - In OR mode, latched edge halts within one instruction
// - Sixteen enabled start/end break ranges
// - Sixteen trace ranges qualify captured cycles
// - Capture all, first cycle or data cycle
// - First-cycle mode drops extra instruction cycles
// - Eight probe levels stored, msb leftmost
// - Pass qualifier feeds trace or break
// - Trigger high only for selected instructions
// - Data mode keeps only table second cycles
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module ebtl_core import ebtl_pkg::*; (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Emulated processor
  input wire ebtl_cyc_t cyc_i,
  output logic halt_o,
  // Probe pins
  input wire logic external_halt_input_i,
  input wire logic [EBTL_NPROBE-1:0] trace_probe_i,
  output logic event_pulse_output_o,
  // Trace buffer write port
  output logic trace_wr_o,
  output ebtl_trace_t trace_data_o,
  // Interrupt
  output logic irq_o
);
  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] ctrl_r;                  // Control fields
  logic [EBTL_NSTAT-1:0] stat_r;       // Sticky events
  logic [EBTL_NSTAT-1:0] mask_r;       // Interrupt enables
  logic [EBTL_AW-1:0] pass_addr_r;     // Qualifier address
  logic [7:0] pass_cnt_r;              // Passes before firing
  logic [7:0] hits_r;                  // Passes seen so far
  logic qual_done_r;                   // Qualifier has fired
  logic [EBTL_NRANGE-1:0] brk_en_r;
  logic [EBTL_NRANGE-1:0] trc_en_r;
  logic [EBTL_NRANGE-1:0] trg_en_r;
  logic ack_r;                         // Access phase answer
  logic [31:0] prdata_r;
  logic slverr_r;
  logic ext_s1_r;                      // Synchroniser stage one
  logic ext_s2_r;                      // Synchroniser stage two
  logic ext_prev_r;                    // Edge detector history
  logic [EBTL_NPROBE-1:0] prb_s1_r;
  logic [EBTL_NPROBE-1:0] prb_s2_r;
  logic ext_latched_r;                 // Edge caught, not yet consumed
  logic halt_r;
  logic trig_r;
  logic trace_wr_r;
  ebtl_trace_t trace_data_r;
  logic acc, wr_acc, setup, is_reg, is_bank, mapped, restart;
  logic ext_edge, inst, ext_ok, pass_hit, qual_fire, int_brk, halt_set;
  logic brk_hit, trc_hit, trg_hit, mode_ok, trc_qual, cap;
  logic [1:0] bank;
  logic [EBTL_AW-1:0] brk_rd, trc_rd, trg_rd, bank_rd;
  logic [31:0] rd_mux;
  ebtl_cap_t mode;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign setup = psel_i && !penable_i;
  assign acc = psel_i && penable_i && ack_r;
  assign wr_acc = acc && pwrite_i;
  assign bank = paddr_i[9:8];
  assign is_bank = (paddr_i[11:10] == 2'h0) && (bank != 2'h0) && !paddr_i[7]
                   && (paddr_i[1:0] == 2'h0);
  assign restart = wr_acc && (paddr_i == EBTL_CMD_OFS) && pwdata_i[0];

  // Register read mux, bits above each field read zero
  always_comb begin
    is_reg = 1'b1;
    rd_mux = 32'h0;
    unique case (paddr_i)
      EBTL_CTRL_OFS: rd_mux[7:0] = ctrl_r;
      EBTL_STAT_OFS: rd_mux[EBTL_NSTAT-1:0] = stat_r;
      EBTL_MASK_OFS: rd_mux[EBTL_NSTAT-1:0] = mask_r;
      EBTL_STATE_OFS: rd_mux[15:0] = {hits_r, 4'h0, trig_r, qual_done_r,
                                      ext_latched_r, halt_r};
      EBTL_PADDR_OFS: rd_mux[EBTL_AW-1:0] = pass_addr_r;
      EBTL_PCNT_OFS: rd_mux[7:0] = pass_cnt_r;
      EBTL_BRKEN_OFS: rd_mux[EBTL_NRANGE-1:0] = brk_en_r;
      EBTL_TRCEN_OFS: rd_mux[EBTL_NRANGE-1:0] = trc_en_r;
      EBTL_TRGEN_OFS: rd_mux[EBTL_NRANGE-1:0] = trg_en_r;
      EBTL_CMD_OFS: rd_mux = 32'h0;
      default: begin
        is_reg = 1'b0;
        rd_mux[EBTL_AW-1:0] = is_bank ? bank_rd : 16'h0;
      end
    endcase
  end
  assign mapped = is_reg || is_bank;
  assign bank_rd = (bank == EBTL_BANK_BRK) ? brk_rd :
                   (bank == EBTL_BANK_TRC) ? trc_rd : trg_rd;

  // Answer is prepared in setup so read data comes from flops
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
      prdata_r <= 32'h0;
      slverr_r <= 1'b0;
    end else begin
      ack_r <= setup;
      if (setup) begin
        prdata_r <= pwrite_i ? 32'h0 : rd_mux;
        slverr_r <= !mapped;
      end
    end
  end
  assign pready_o = acc;
  assign pslverr_o = acc && slverr_r;
  assign prdata_o = prdata_r;

  // Software-written configuration; unmapped writes change nothing
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= EBTL_CTRL_RST;
      mask_r <= EBTL_MASK_RST;
      pass_addr_r <= '0;
      pass_cnt_r <= 8'h0;
      brk_en_r <= '0;
      trc_en_r <= '0;
      trg_en_r <= '0;
    end else if (wr_acc) begin
      unique case (paddr_i)
        EBTL_CTRL_OFS: ctrl_r <= pwdata_i[7:0];
        EBTL_MASK_OFS: mask_r <= pwdata_i[EBTL_NSTAT-1:0];
        EBTL_PADDR_OFS: pass_addr_r <= pwdata_i[EBTL_AW-1:0];
        EBTL_PCNT_OFS: pass_cnt_r <= pwdata_i[7:0];
        EBTL_BRKEN_OFS: brk_en_r <= pwdata_i[EBTL_NRANGE-1:0];
        EBTL_TRCEN_OFS: trc_en_r <= pwdata_i[EBTL_NRANGE-1:0];
        EBTL_TRGEN_OFS: trg_en_r <= pwdata_i[EBTL_NRANGE-1:0];
        default: ;  // Status, state and banks handled elsewhere
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Range banks
  // Break ranges
  ebtl_range_bank u_brk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .wr_i(wr_acc && is_bank && bank == EBTL_BANK_BRK), .idx_i(paddr_i[6:3]),
    .end_sel_i(paddr_i[2]), .data_i(pwdata_i[EBTL_AW-1:0]), .rd_o(brk_rd),
    .en_i(brk_en_r), .addr_i(cyc_i.addr), .hit_o(brk_hit));
  // Trace ranges
  ebtl_range_bank u_trc (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .wr_i(wr_acc && is_bank && bank == EBTL_BANK_TRC), .idx_i(paddr_i[6:3]),
    .end_sel_i(paddr_i[2]), .data_i(pwdata_i[EBTL_AW-1:0]), .rd_o(trc_rd),
    .en_i(trc_en_r), .addr_i(cyc_i.addr), .hit_o(trc_hit));
  // Trigger ranges
  ebtl_range_bank u_trg (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .wr_i(wr_acc && is_bank && bank == EBTL_BANK_TRG), .idx_i(paddr_i[6:3]),
    .end_sel_i(paddr_i[2]), .data_i(pwdata_i[EBTL_AW-1:0]), .rd_o(trg_rd),
    .en_i(trg_en_r), .addr_i(cyc_i.addr), .hit_o(trg_hit));

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge latch
  // Pins are asynchronous to the emulated clock
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_prev_r <= 1'b0;
      prb_s1_r <= '0;
      prb_s2_r <= '0;
    end else begin
      ext_s1_r <= external_halt_input_i;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
      prb_s1_r <= trace_probe_i;
      prb_s2_r <= prb_s1_r;
    end
  end

  // Polarity selects which transition counts
  assign ext_edge = ctrl_r[EBTL_C_FALL] ? (ext_prev_r && !ext_s2_r)
                                        : (!ext_prev_r && ext_s2_r);

  // Latch holds until restart; a fresh edge beats the clear
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_latched_r <= 1'b0;
    end else if (ctrl_r[EBTL_C_EXT_EN] && ext_edge) begin
      ext_latched_r <= 1'b1;
    end else if (restart) begin
      ext_latched_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pass qualifier
  assign inst = cyc_i.valid && cyc_i.first && !halt_r;
  assign pass_hit = inst && ctrl_r[EBTL_C_QUAL_EN] && (cyc_i.addr == pass_addr_r);
  assign qual_fire = pass_hit && !qual_done_r && (hits_r == pass_cnt_r);

  // Counts passes; fires once until restart
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hits_r <= 8'h0;
      qual_done_r <= 1'b0;
    end else if (restart) begin
      hits_r <= 8'h0;
      qual_done_r <= 1'b0;
    end else if (qual_fire) begin
      qual_done_r <= 1'b1;
    end else if (pass_hit && !qual_done_r) begin
      hits_r <= hits_r + 8'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Halt decision, taken at each instruction's first cycle
  assign int_brk = brk_hit || (ctrl_r[EBTL_C_QUAL_BRK] && qual_fire);
  assign ext_ok = ctrl_r[EBTL_C_EXT_EN] && ext_latched_r;
  always_comb begin
    if (ctrl_r[EBTL_C_EXT_EN] && ctrl_r[EBTL_C_AND]) begin
      halt_set = inst && int_brk && ext_ok;
    end else begin
      halt_set = inst && (int_brk || ext_ok);
    end
  end

  // Halt stands until restart; a new break beats the clear
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      halt_r <= 1'b0;
    end else if (halt_set) begin
      halt_r <= 1'b1;
    end else if (restart) begin
      halt_r <= 1'b0;
    end
  end
  assign halt_o = halt_r;

  // Trigger follows each instruction, for cross-coupling units
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_r <= 1'b0;
    end else if (inst) begin
      trig_r <= trg_hit;
    end
  end
  assign event_pulse_output_o = trig_r;

  //////////////////////////////////////////////////////////////////////////////
  // Trace capture
  assign mode = ebtl_cap_t'(ctrl_r[EBTL_C_MODE +: 2]);
  always_comb begin
    unique case (mode)
      EBTL_CAP_ALL: mode_ok = 1'b1;
      EBTL_CAP_FIRST: mode_ok = cyc_i.first;
      EBTL_CAP_DATA: mode_ok = cyc_i.table_cycle;
      default: mode_ok = 1'b1;  // Spare code behaves as capture all
    endcase
  end
  // Qualifier on trace side holds capture off until it fires
  assign trc_qual = !ctrl_r[EBTL_C_QUAL_EN] || ctrl_r[EBTL_C_QUAL_BRK] || qual_done_r;
  assign cap = cyc_i.valid && ctrl_r[EBTL_C_TRC_EN] && trc_hit && mode_ok && trc_qual;

  // Entry pairs address with synchronised probe levels
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trace_wr_r <= 1'b0;
      trace_data_r <= '0;
    end else begin
      trace_wr_r <= cap;
      if (cap) begin
        trace_data_r <= '{addr: cyc_i.addr, probes: prb_s2_r};
      end
    end
  end
  assign trace_wr_o = trace_wr_r;
  assign trace_data_o = trace_data_r;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status; hardware set beats software clear
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stat_r <= '0;
    end else begin
      for (int i = 0; i < EBTL_NSTAT; i++) begin
        if (wr_acc && paddr_i == EBTL_STAT_OFS && pwdata_i[i]) begin
          stat_r[i] <= 1'b0;
        end
      end
      if (halt_set && !halt_r) stat_r[EBTL_S_HALT] <= 1'b1;
      if (ctrl_r[EBTL_C_EXT_EN] && ext_edge) stat_r[EBTL_S_EXT] <= 1'b1;
      if (inst && trg_hit && !trig_r) stat_r[EBTL_S_TRIG] <= 1'b1;
    end
  end
  assign irq_o = |(stat_r & mask_r);

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_edge_caught;
    ctrl_r[EBTL_C_EXT_EN] && !ctrl_r[EBTL_C_FALL] && $rose(ext_s2_r) ##1 ext_latched_r;
  endsequence
  sequence s_inst_ext;
    inst && ext_ok && !(ctrl_r[EBTL_C_AND]);
  endsequence

  property p_or_halt;
    @(posedge core_clk_i) disable iff (!reset_n_i) s_inst_ext |=> halt_r;
  endproperty
  a_or_halt: assert property (p_or_halt) else $error("OR halt missed");

  property p_ext_one_inst;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_edge_caught ##0 (!ctrl_r[EBTL_C_AND] && !restart) ##[0:8] inst |=> halt_r;
  endproperty
  a_ext_one_inst: assert property (p_ext_one_inst) else $error("late halt");

  property p_and_halt;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(halt_r) && $past(ctrl_r[EBTL_C_AND] && ctrl_r[EBTL_C_EXT_EN])
      |-> $past(int_brk && ext_latched_r);
  endproperty
  a_and_halt: assert property (p_and_halt) else $error("AND halt wrong");

  property p_fall_latch;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      ctrl_r[EBTL_C_EXT_EN] && ctrl_r[EBTL_C_FALL] && $fell(ext_s2_r) |=> ext_latched_r;
  endproperty
  a_fall_latch: assert property (p_fall_latch) else $error("edge lost");

  property p_brk_range;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      inst && brk_hit && !(ctrl_r[EBTL_C_AND] && ctrl_r[EBTL_C_EXT_EN]) |=> halt_r;
  endproperty
  a_brk_range: assert property (p_brk_range) else $error("no break");

  property p_trace_range;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      trace_wr_r |-> $past(trc_hit && cyc_i.valid);
  endproperty
  a_trace_range: assert property (p_trace_range) else $error("bad capture");

  property p_first_only;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      trace_wr_r && $past(mode == EBTL_CAP_FIRST) |-> $past(cyc_i.first);
  endproperty
  a_first_only: assert property (p_first_only) else $error("extra cycle");

  property p_data_only;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      trace_wr_r && $past(mode == EBTL_CAP_DATA) |-> $past(cyc_i.table_cycle);
  endproperty
  a_data_only: assert property (p_data_only) else $error("not data");

  property p_probes;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      trace_wr_r |-> trace_data_r.probes == $past(prb_s2_r);
  endproperty
  a_probes: assert property (p_probes) else $error("probe mismatch");

  property p_qual_brk;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      qual_fire && ctrl_r[EBTL_C_QUAL_BRK] && !ctrl_r[EBTL_C_AND] |=> halt_r;
  endproperty
  a_qual_brk: assert property (p_qual_brk) else $error("qual no break");

  property p_trig;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      inst |=> event_pulse_output_o == $past(trg_hit);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger wrong");

  property p_restart;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      restart && !(ctrl_r[EBTL_C_EXT_EN] && ext_edge) |=> !ext_latched_r;
  endproperty
  a_restart: assert property (p_restart) else $error("stale latch");
endmodule // ebtl_core

// ===== testbench/ebtl_target_model.sv
// Purpose: Target board side driving the halt and trace probe pins
// Assumes: Pins are push-pull and always driven, never floating
// Notes: Each level is held long enough to cross the pin synchronisers
`timescale 1ns/1ps
module ebtl_target_model (
  // Clock
  input wire logic core_clk_i,
  // Probe pins
  output logic external_halt_input_o,
  output logic [7:0] trace_probe_o
);
  // Pins start low
  initial begin
    external_halt_input_o = 1'b0;
    trace_probe_o = 8'h00;
  end

  // New halt pin level, held four clocks so sync and latch settle
  task automatic set_pin(input logic v);
    @(posedge core_clk_i);
    external_halt_input_o <= v;
    repeat (4) @(posedge core_clk_i);
  endtask

  // Probe levels, held until changed again
  task automatic set_probes(input logic [7:0] v);
    @(posedge core_clk_i);
    trace_probe_o <= v;
    repeat (3) @(posedge core_clk_i);
  endtask
endmodule // ebtl_target_model

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for break, trigger and trace logic
// Assumes: Zero-wait APB slave, halt one clock after the instruction
// Notes: Probe pins come from the target model
`timescale 1ns/1ps
module tb_top import ebtl_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0; // Clock and reset
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0; // APB request
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, q;
  logic pready, perr, err, halt, evt, twr, irq, ext;
  logic [7:0] prb;
  ebtl_cyc_t cyc = '0; // Processor cycle
  ebtl_trace_t tdat, last;
  int miscompares = 0, n_tests = 0, ntr = 0;
  int exp_n [4] = '{3, 2, 1, 3}; // Captures per mode: all, first, data, spare

  always #4 clk = ~clk;

  ebtl_core ebtl_core_i (.core_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(pready), .pslverr_o(perr), .cyc_i(cyc), .halt_o(halt),
    .external_halt_input_i(ext), .trace_probe_i(prb), .event_pulse_output_o(evt),
    .trace_wr_o(twr), .trace_data_o(tdat), .irq_o(irq));
  ebtl_target_model ebtl_target_model_i (.core_clk_i(clk),
    .external_halt_input_o(ext), .trace_probe_o(prb));

  // Count trace writes and keep the latest entry
  always @(posedge clk) if (twr === 1'b1) begin
    ntr++;
    last = tdat;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, s, e);
    end
  endtask

  // One APB transfer; waits for pready, the watchdog bounds the wait
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prd;
    err = perr;
    psel <= 1'b0; pen <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // Range table byte address: bank, entry, end word
  function automatic logic [11:0] ra(input logic [1:0] b, input logic [3:0] i, input logic e);
    return {2'b00, b, 1'b0, i, e, 2'b00};
  endfunction

  task automatic set_rng(input logic [1:0] b, input logic [3:0] i, input logic [15:0] s,
      input logic [15:0] e);
    wr(ra(b, i, 1'b0), {16'h0, s});
    wr(ra(b, i, 1'b1), {16'h0, e});
  endtask

  // One processor cycle, then a settle step after the sampling edge
  task automatic ins(input logic f, input logic t, input logic [15:0] a);
    @(posedge clk);
    cyc <= {1'b1, f, t, a};
    @(posedge clk);
    cyc <= '0;
    #1;
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the tests need well under 3000 clocks
  initial begin
    #100000;
    miscompares++;
    summarize;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, EBTL_CTRL_OFS, 32'h0); chk(q, 32'h80, "ctrl reset");
    xfer(1'b0, EBTL_MASK_OFS, 32'h0); chk(q, 32'h0, "mask reset");
    xfer(1'b0, 12'h0f0, 32'h0); chk({q[30:0], err}, 32'h1, "unmapped");
    $display("test reset done");
    // Break range at the last entry, inclusive end
    set_rng(EBTL_BANK_BRK, 4'hf, 16'h0010, 16'h0020);
    wr(EBTL_BRKEN_OFS, 32'h8000);
    // Range table reads back what was written
    xfer(1'b0, ra(EBTL_BANK_BRK, 4'hf, 1'b1), 32'h0); chk(q, 32'h20, "range end");
    wr(EBTL_MASK_OFS, 32'h1);
    ins(1'b1, 1'b0, 16'h0021); chk(halt, 1'b0, "past end");
    ins(1'b1, 1'b0, 16'h0020); chk(halt, 1'b1, "break hit");
    chk(irq, 1'b1, "halt irq");
    wr(EBTL_STAT_OFS, 32'h1);
    wr(EBTL_CMD_OFS, 32'h1); chk({halt, irq}, 2'b00, "restart");
    $display("test break range done");
    // External edge in OR mode, both polarities; wrong edge first
    for (int p = 0; p < 2; p++) begin
      wr(EBTL_CTRL_OFS, 32'h80);
      ebtl_target_model_i.set_pin(!p);
      wr(EBTL_CTRL_OFS, 32'h81 | (p << 2));
      ebtl_target_model_i.set_pin(p[0]);
      repeat (2) ins(1'b1, 1'b0, 16'h0100);
      chk(halt, 1'b0, "wrong edge");
      ebtl_target_model_i.set_pin(!p);
      repeat (2) ins(1'b1, 1'b0, 16'h0100);
      chk(halt, 1'b1, "edge halt");
      wr(EBTL_CMD_OFS, 32'h1);
    end
    $display("test external edge done");
    // AND mode: edge alone, then edge with range hit, then restart clears
    wr(EBTL_CTRL_OFS, 32'h83);
    ebtl_target_model_i.set_pin(1'b1);
    repeat (2) ins(1'b1, 1'b0, 16'h0100);
    chk(halt, 1'b0, "and no hit");
    ins(1'b1, 1'b0, 16'h0015); chk(halt, 1'b1, "and hit");
    wr(EBTL_CMD_OFS, 32'h1);
    ins(1'b1, 1'b0, 16'h0015); chk(halt, 1'b0, "stale edge");
    wr(EBTL_CTRL_OFS, 32'h80);
    ebtl_target_model_i.set_pin(1'b0);
    $display("test and mode done");
    // Pass qualifier to break, second pass fires
    wr(EBTL_CTRL_OFS, 32'he0);
    wr(EBTL_PADDR_OFS, 32'h30);
    wr(EBTL_PCNT_OFS, 32'h1);
    wr(EBTL_CMD_OFS, 32'h1);
    ins(1'b1, 1'b0, 16'h0030); chk(halt, 1'b0, "pass one");
    ins(1'b1, 1'b0, 16'h0030); chk(halt, 1'b1, "pass two");
    wr(EBTL_CMD_OFS, 32'h1);
    $display("test qualifier done");
    // Trace modes over one fixed cycle pattern
    set_rng(EBTL_BANK_TRC, 4'h0, 16'h0040, 16'h004f);
    wr(EBTL_TRCEN_OFS, 32'h1);
    // Probe pattern is not bit-symmetric, so a swapped order shows
    ebtl_target_model_i.set_probes(8'hc1);
    for (int m = 0; m < 4; m++) begin
      wr(EBTL_CTRL_OFS, 32'h80 | (m << 3));
      ntr = 0;
      ins(1'b1, 1'b0, 16'h0041);
      ins(1'b0, 1'b1, 16'h0042);
      ins(1'b1, 1'b0, 16'h0043);
      ins(1'b1, 1'b0, 16'h0060);
      repeat (2) @(posedge clk);
      #1 chk(ntr, exp_n[m], "capture count");
    end
    chk({8'h0, last}, {8'h0, 16'h0043, 8'hc1}, "table entry");
    $display("test trace done");
    // Trigger range and its interrupt
    set_rng(EBTL_BANK_TRG, 4'h1, 16'h0070, 16'h0070);
    wr(EBTL_TRGEN_OFS, 32'h2);
    wr(EBTL_MASK_OFS, 32'h4);
    ins(1'b1, 1'b0, 16'h0070); chk(evt, 1'b1, "trig high");
    chk(irq, 1'b1, "trig irq");
    ins(1'b1, 1'b0, 16'h0071); chk(evt, 1'b0, "trig low");
    wr(EBTL_STAT_OFS, 32'h4); chk(irq, 1'b0, "irq clear");
    $display("test trigger done");
    // Mid-run reset returns configuration to its reset values
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, EBTL_CTRL_OFS, 32'h0); chk(q, 32'h80, "ctrl after reset");
    xfer(1'b0, EBTL_MASK_OFS, 32'h0); chk(q, 32'h0, "mask after reset");
    chk({halt, evt, irq, twr}, 4'h0, "outputs after reset");
    $display("test second reset done");
    summarize;
  end
endmodule // tb_top
